// >>> src/lps_serializer.sv
`timescale 1ns/100ps
`include "lps_cfg.svh"

// How it works
// RQ1 - Each captured word is sent as seven serial slots per pixel period.
// RQ2 - Slot 0, at clock rise: lanes carry bits 1, 9, 20, 5.
// RQ3 - Slot 1: lanes carry bits 0, 8, 19, 27.
// RQ4 - Slot 2: lanes carry bits 7, 18, 26, 23.
// RQ5 - Slot 3: lanes carry bits 6, 15, 25, 17.
// RQ6 - Slot 4: lanes carry bits 4, 14, 24, 16.
// RQ7 - Slot 5: lanes carry bits 3, 13, 22, 11.
// RQ8 - Slot 6, last of the period: lanes carry bits 2, 12, 21, 10.
// RQ9 - Forwarded clock is high for slots 0 to 3, low for 4 to 6.
// RQ10 - After power-up, wait the lock time before driving valid lane data.
// RQ11 - Power-down releases all outputs, forwarded clock included, to off state.
// RQ12 - The host presents video, syncs, enable and spare bit per pixel.
// RQ13 - Inputs are captured on the rising or falling pixel clock edge.
// RQ14 - Edge select high picks rising capture, low picks falling capture.
// RQ15 - Power-down stops the link and forces every register to zero; the code sets oe_n_q to one and leaves the synchronisers sampling.
// RQ16 - Forwarded clock period equals the pixel clock period, seven slots each.
module lps_serializer
    import lps_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RESETN_I,
    input  wire logic        PIXEL_CLOCK_IN_I,
    input  wire logic [27:0] PARALLEL_INPUT_BIT_I,
    input  wire logic        CAPTURE_EDGE_SELECT_I,
    input  wire logic        POWER_DOWN_N_I,
    output logic [3:0]       SERIAL_LANE_O,
    output logic [3:0]       SERIAL_LANE_OE_N_O,
    output logic             FORWARDED_CLOCK_O,
    output logic             FORWARDED_CLOCK_OE_N_O,
    output logic             LINK_LOCKED_O
);

    localparam int LOCK_CYC = `LPS_LOCK_CYC;
    localparam int DIS_CYC  = `LPS_DIS_CYC;
    localparam int LCK_W    = $clog2(LOCK_CYC + 1);

    logic              pclk_s1_q;
    logic              pclk_s2_q;
    logic              pclk_s3_q;
    logic              sel_s1_q;
    logic              sel_s2_q;
    logic              pd_s1_q;
    logic              pd_s2_q;
    logic [27:0]       data_s1_q;
    logic [27:0]       data_s2_q;
    logic [27:0]       data_s3_q;
    logic              rise;
    logic              fall;
    logic              cap_edge;
    logic              clear;
    logic [27:0]       hold_q;
    logic [27:0]       word_q;
    logic [27:0]       cur;
    logic [3:0]        lane_q;
    logic              fwd_q;
    logic              oe_n_q;
    logic [LCK_W-1:0]  lock_cnt_q;
    lps_state_t        state_q;
    lps_slot_t         slot;
    logic              load;
    logic              valid;
    logic              run;
    logic              go;

    // Maps one slot of a word onto the four lanes, lane 0 in bit 0.
    function automatic logic [3:0] lane_map(input logic [27:0] w, input lps_slot_t s);
        case (s)
            3'h0: lane_map = {w[5], w[20], w[9], w[1]};
            3'h1: lane_map = {w[27], w[19], w[8], w[0]};
            3'h2: lane_map = {w[23], w[26], w[18], w[7]};
            3'h3: lane_map = {w[17], w[25], w[15], w[6]};
            3'h4: lane_map = {w[16], w[24], w[14], w[4]};
            3'h5: lane_map = {w[11], w[22], w[13], w[3]};
            3'h6: lane_map = {w[10], w[21], w[12], w[2]};
            default: lane_map = 4'h0;
        endcase
    endfunction

    // ********************************************************
    // Input synchronisers.
    // ********************************************************
    // Pixel clock and data share depth, and the third stage gives the
    // data as it stood just before the detected edge, honouring setup.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_s3_q <= 1'b0;
            sel_s1_q  <= 1'b0;
            sel_s2_q  <= 1'b0;
            pd_s1_q   <= 1'b0;
            pd_s2_q   <= 1'b0;
            data_s1_q <= 28'h0000000;
            data_s2_q <= 28'h0000000;
            data_s3_q <= 28'h0000000;
        end else begin
            pclk_s1_q <= PIXEL_CLOCK_IN_I;
            pclk_s2_q <= pclk_s1_q;
            pclk_s3_q <= pclk_s2_q;
            sel_s1_q  <= CAPTURE_EDGE_SELECT_I;
            sel_s2_q  <= sel_s1_q;
            pd_s1_q   <= POWER_DOWN_N_I;
            pd_s2_q   <= pd_s1_q;
            data_s1_q <= PARALLEL_INPUT_BIT_I;
            data_s2_q <= data_s1_q;
            data_s3_q <= data_s2_q;
        end
    end

    // Edge choice and the power-down clear.
    assign rise     = pclk_s2_q & ~pclk_s3_q;
    assign fall     = ~pclk_s2_q & pclk_s3_q;
    assign clear    = ~pd_s2_q; // RQ15
    assign cap_edge = pd_s2_q & (sel_s2_q ? rise : fall); // RQ14

    // ********************************************************
    // Slot timing.
    // ********************************************************
    lps_slot_gen #(
        .CNT_W   (CNT_W)
    ) u_slot_gen (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESETN_I),
        .clear_i (clear),
        .edge_i  (cap_edge),
        .slot_o  (slot),
        .load_o  (load),
        .valid_o (valid)
    );

    // ********************************************************
    // Capture and load.
    // ********************************************************
    // The holding register takes the word on the chosen edge.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hold_q <= 28'h0000000;
        end else if (clear) begin
            hold_q <= 28'h0000000; // RQ15
        end else if (cap_edge) begin
            hold_q <= data_s3_q; // RQ13
        end
    end

    // The shift word is reloaded as slot 0 starts; cur bypasses it so
    // slot 0 already carries the new word.
    assign cur = load ? hold_q : word_q;

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            word_q <= 28'h0000000;
        end else if (clear) begin
            word_q <= 28'h0000000;
        end else if (load) begin
            word_q <= hold_q; // RQ1
        end
    end

    // ********************************************************
    // Lock sequencing.
    // ********************************************************
    // The lock wait stands in for the bit-rate synthesizer settling;
    // it also needs two clean edges so the slot period is known.
    // Run starts only on a capture edge, so the first period on the lanes is whole.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_q    <= LPS_OFF;
            lock_cnt_q <= '0;
        end else if (clear) begin
            state_q    <= LPS_OFF;
            lock_cnt_q <= '0;
        end else begin
            case (state_q)
                LPS_OFF: begin
                    state_q <= LPS_LOCK;
                end
                LPS_LOCK: begin
                    if (lock_cnt_q != LCK_W'(LOCK_CYC - 1)) begin
                        lock_cnt_q <= lock_cnt_q + 1'b1;
                    end else if (valid && cap_edge) begin
                        state_q <= LPS_RUN; // RQ10
                    end
                end
                LPS_RUN: begin
                    state_q <= LPS_RUN;
                end
                default: begin
                    state_q <= LPS_OFF;
                end
            endcase
        end
    end

    assign run = (state_q == LPS_RUN);
    assign go  = run & pd_s2_q;

    // ********************************************************
    // Lane and clock output registers.
    // ********************************************************
    // Lanes and clock share one register stage so they stay aligned.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            lane_q <= 4'h0;
            fwd_q  <= 1'b0;
        end else if (!go) begin
            lane_q <= 4'h0;
            fwd_q  <= 1'b0;
        end else begin
            lane_q <= lane_map(cur, slot); // RQ2 RQ3 RQ4 RQ5 RQ6 RQ7 RQ8
            fwd_q  <= (slot < 3'(`LPS_CLK_HIGH_SLOTS)); // RQ9 RQ16
        end
    end

    // Drivers switch off one cycle after the synchronised power-down.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~pd_s2_q; // RQ11
        end
    end

    assign SERIAL_LANE_O          = lane_q;
    assign SERIAL_LANE_OE_N_O     = {`LPS_LANES{oe_n_q}};
    assign FORWARDED_CLOCK_O      = fwd_q;
    assign FORWARDED_CLOCK_OE_N_O = oe_n_q;
    assign LINK_LOCKED_O          = run;

    // ********************************************************
    // Checks.
    // ********************************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    a_slot0_lanes: assert property (go && slot == 3'h0 // RQ2
        |=> lane_q == $past({cur[5], cur[20], cur[9], cur[1]})) else $error("Slot 0 lanes wrong.");
    a_slot1_lanes: assert property (go && slot == 3'h1 // RQ3
        |=> lane_q == $past({cur[27], cur[19], cur[8], cur[0]})) else $error("Slot 1 lanes wrong.");
    a_slot2_lanes: assert property (go && slot == 3'h2 // RQ4
        |=> lane_q == $past({cur[23], cur[26], cur[18], cur[7]})) else $error("Slot 2 lanes wrong.");
    a_slot3_lanes: assert property (go && slot == 3'h3 // RQ5
        |=> lane_q == $past({cur[17], cur[25], cur[15], cur[6]})) else $error("Slot 3 lanes wrong.");
    a_slot4_lanes: assert property (go && slot == 3'h4 // RQ6
        |=> lane_q == $past({cur[16], cur[24], cur[14], cur[4]})) else $error("Slot 4 lanes wrong.");
    a_slot5_lanes: assert property (go && slot == 3'h5 // RQ7
        |=> lane_q == $past({cur[11], cur[22], cur[13], cur[3]})) else $error("Slot 5 lanes wrong.");
    a_slot6_lanes: assert property (go && slot == 3'h6 // RQ8
        |=> lane_q == $past({cur[10], cur[21], cur[12], cur[2]})) else $error("Slot 6 lanes wrong.");
    a_fwd_duty: assert property (go |=> fwd_q == ($past(slot) < 3'h4)) // RQ9
        else $error("Forwarded clock level wrong for slot.");
    a_fwd_period: assert property ($rose(fwd_q) && $past(go, 2) |-> $past(load)) // RQ16
        else $error("Forwarded clock rose without a new period.");
    a_rise_capture: assert property (pd_s2_q && sel_s2_q && rise // RQ14
        |=> hold_q == $past(data_s3_q)) else $error("Rising capture missed.");
    a_fall_capture: assert property (pd_s2_q && !sel_s2_q && fall // RQ13
        |=> hold_q == $past(data_s3_q)) else $error("Falling capture missed.");
    a_load_word: assert property (load && pd_s2_q |=> word_q == $past(hold_q)) // RQ1
        else $error("Word not loaded at slot 0.");
    a_clear_all: assert property (!pd_s2_q // RQ15
        |=> hold_q == 28'h0000000 && word_q == 28'h0000000 && lane_q == 4'h0 && !fwd_q && !run)
        else $error("Power-down left state set.");
    a_off_state: assert property ($fell(pd_s2_q) |-> ##[1:DIS_CYC] oe_n_q) // RQ11
        else $error("Drivers not released after power-down.");
    a_lock_wait: assert property ($rose(run) // RQ10
        |-> $past(state_q) == LPS_LOCK && $past(cap_edge) && lock_cnt_q == LCK_W'(LOCK_CYC - 1))
        else $error("Link ran before the lock time.");

    c_lock_done: cover property ($rose(run));
    c_slot_wrap: cover property (go && slot == 3'h6 ##1 slot == 3'h0);
    c_fall_edge: cover property (go && !sel_s2_q && fall);
    c_shut_run:  cover property (run && $fell(pd_s2_q));

endmodule

// >>> src/lps_cfg.svh
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH

// ********************************************************
// Timing of the system clock and of the link.
// ********************************************************
`define LPS_CLK_PERIOD_NS  10
`define LPS_LOCK_TIME_NS   6000
`define LPS_LOCK_CYC       ((`LPS_LOCK_TIME_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_DIS_TIME_NS    7
`define LPS_DIS_RAW        (`LPS_DIS_TIME_NS / `LPS_CLK_PERIOD_NS)
`define LPS_DIS_CYC        ((`LPS_DIS_RAW < 1) ? 1 : `LPS_DIS_RAW)

// ********************************************************
// Framing of one pixel period on the lanes.
// ********************************************************
`define LPS_SLOTS          7
`define LPS_LAST_SLOT      6
`define LPS_CLK_HIGH_SLOTS 4
`define LPS_LANES          4
`define LPS_WORD_W         28

`endif

// >>> src/lps_pkg.sv
// ********************************************************
// Types shared by the serializer modules.
// ********************************************************
package lps_pkg;
    typedef logic [2:0] lps_slot_t;
    typedef enum logic [1:0] {
        LPS_OFF  = 2'b00,
        LPS_LOCK = 2'b01,
        LPS_RUN  = 2'b10
    } lps_state_t;
endpackage

// >>> src/lps_slot_gen.sv
`timescale 1ns/100ps
`include "lps_cfg.svh"

// Splits each measured pixel period into seven slot steps with a
// fractional accumulator, so no fast bit clock is needed.
module lps_slot_gen
    import lps_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      clear_i,
    input  wire logic      edge_i,
    output lps_slot_t      slot_o,
    output logic           load_o,
    output logic           valid_o
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W:0]   acc_q;
    logic [CNT_W:0]   sum;
    logic [CNT_W:0]   per_ext;
    logic [1:0]       edges_q;
    lps_slot_t        slot_q;
    logic             load_q;

    // ********************************************************
    // Period measurement.
    // ********************************************************
    // The counter saturates so a stalled pixel clock cannot wrap it.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q    <= '0;
            period_q <= '0;
            edges_q  <= 2'h0;
        end else if (clear_i) begin
            cnt_q    <= '0;
            period_q <= '0;
            edges_q  <= 2'h0;
        end else if (edge_i) begin
            period_q <= cnt_q + 1'b1;
            cnt_q    <= '0;
            if (edges_q != 2'h2) begin
                edges_q <= edges_q + 2'h1;
            end
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign valid_o = (edges_q == 2'h2);
    assign per_ext = {1'b0, period_q};
    assign sum     = acc_q + (CNT_W+1)'(`LPS_SLOTS);

    // ********************************************************
    // Slot stepping.
    // ********************************************************
    // Each edge restarts slot 0, so rounding error never builds up
    // beyond one period; slot 6 absorbs the remainder.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q  <= '0;
            slot_q <= 3'h0;
            load_q <= 1'b0;
        end else if (clear_i) begin
            acc_q  <= '0;
            slot_q <= 3'h0;
            load_q <= 1'b0;
        end else begin
            load_q <= edge_i;
            if (edge_i) begin
                acc_q  <= '0; // RQ2
                slot_q <= 3'h0;
            end else if (valid_o) begin
                if (sum >= per_ext) begin
                    acc_q <= sum - per_ext; // RQ1
                    if (slot_q != 3'(`LPS_LAST_SLOT)) begin
                        slot_q <= slot_q + 3'h1;
                    end
                end else begin
                    acc_q <= sum;
                end
            end
        end
    end

    assign slot_o = slot_q;
    assign load_o = load_q;

    // ********************************************************
    // Checks.
    // ********************************************************
    a_slot_step: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
        !clear_i && !edge_i |=> slot_q == $past(slot_q) || slot_q == $past(slot_q) + 3'h1)
        else $error("Slot index skipped a step.");

    a_slot_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
        edge_i |=> slot_q == 3'h0 && load_q)
        else $error("Edge did not restart slot zero.");

endmodule

// >>> test/lps_host_model.sv
`timescale 1ns/100ps

// ********************************************************
// Host side: pixel clock and pixel words.
// ********************************************************

// The pixel clock runs free, out of phase with the system clock.
// Data moves only on the edge that is not the capture edge. That gives
// half a pixel period of setup and hold around the capture edge.
module lps_host_model #(
    parameter real HALF_NS  = 40.0,
    parameter real PHASE_NS = 3.3
) (
    input  wire logic        sel_i,
    output logic             pclk_o,
    output logic [27:0]      data_o
);
    logic [31:0] rng_q = 32'h4B2E116A;

    // Xorshift generator, so the run repeats exactly from the fixed seed.
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // A clock edge whose new level differs from the select level is the non-capture edge.
    initial begin
        pclk_o = 1'b0;
        data_o = 28'h0000000;
        #(PHASE_NS);
        forever begin
            #(HALF_NS);
            pclk_o = ~pclk_o;
            if (pclk_o !== sel_i) begin
                rng_q  = xorshift(rng_q);
                data_o = rng_q[27:0];
            end
        end
    end
endmodule

// >>> test/lps_serializer_tb_top.sv
`timescale 1ns/100ps
`include "lps_cfg.svh"

module lps_serializer_tb_top
    import lps_pkg::*;
;
    // ********************************************************
    // Lane map, bench signals and instances.
    // ********************************************************
    localparam int MAP [7][4] = '{'{1, 9, 20, 5}, '{0, 8, 19, 27}, '{7, 18, 26, 23}, '{6, 15, 25, 17},
                                  '{4, 14, 24, 16}, '{3, 13, 22, 11}, '{2, 12, 21, 10}};
    localparam int CEILING = 4000;

    logic             CLK_SYS_I             = 1'b0;
    logic             RESETN_I              = 1'b0;
    logic             CAPTURE_EDGE_SELECT_I = 1'b1;
    logic             POWER_DOWN_N_I        = 1'b0;
    wire logic        PIXEL_CLOCK_IN_I;
    wire logic [27:0] PARALLEL_INPUT_BIT_I;
    wire logic [3:0]  SERIAL_LANE_O;
    wire logic [3:0]  SERIAL_LANE_OE_N_O;
    wire logic        FORWARDED_CLOCK_O;
    wire logic        FORWARDED_CLOCK_OE_N_O;
    wire logic        LINK_LOCKED_O;
    logic [27:0]      exp_q[$];
    logic [27:0]      cur_exp;
    logic [3:0]       lane_s [16];
    logic             fwd_s [16];
    logic             have_exp = 1'b0;
    logic             fwd_prev = 1'b0;
    int               n_smp = 0;
    int               n_per = 0;
    int               cycles = 0;
    int               miscompares = 0;
    int               cmp_count = 0;

    always #5 CLK_SYS_I = ~CLK_SYS_I;

    lps_host_model u_lps_host_model (
        .sel_i  (CAPTURE_EDGE_SELECT_I),
        .pclk_o (PIXEL_CLOCK_IN_I),
        .data_o (PARALLEL_INPUT_BIT_I)
    );

    lps_serializer #(
        .CNT_W (8)
    ) u_lps_serializer (
        .CLK_SYS_I              (CLK_SYS_I),
        .RESETN_I               (RESETN_I),
        .PIXEL_CLOCK_IN_I       (PIXEL_CLOCK_IN_I),
        .PARALLEL_INPUT_BIT_I   (PARALLEL_INPUT_BIT_I),
        .CAPTURE_EDGE_SELECT_I  (CAPTURE_EDGE_SELECT_I),
        .POWER_DOWN_N_I         (POWER_DOWN_N_I),
        .SERIAL_LANE_O          (SERIAL_LANE_O),
        .SERIAL_LANE_OE_N_O     (SERIAL_LANE_OE_N_O),
        .FORWARDED_CLOCK_O      (FORWARDED_CLOCK_O),
        .FORWARDED_CLOCK_OE_N_O (FORWARDED_CLOCK_OE_N_O),
        .LINK_LOCKED_O          (LINK_LOCKED_O)
    );

    // ********************************************************
    // Comparison and closing.
    // ********************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One period holds eight system cycles: slot 0 stands twice, then slots 1 to 6.
    task automatic check_period();
        logic [3:0] e;
        chk("samples_per_period", 32'(n_smp), 32'h8);
        for (int s = 0; s < 7; s++) begin
            for (int l = 0; l < 4; l++) begin
                e[l] = cur_exp[MAP[s][l]];
            end
            chk("lane_slot", 32'(lane_s[(s == 0) ? 0 : s + 1]), 32'(e));
            chk("fwd_slot", 32'(fwd_s[(s == 0) ? 0 : s + 1]), 32'(s < 4));
        end
        chk("lane_slot0_held", 32'(lane_s[1]), 32'({cur_exp[5], cur_exp[20], cur_exp[9], cur_exp[1]}));
        n_per++;
    endtask

    // The driver notes every word present at the selected capture edge.
    always @(PIXEL_CLOCK_IN_I) begin
        if (PIXEL_CLOCK_IN_I === CAPTURE_EDGE_SELECT_I) begin
            exp_q.push_back(PARALLEL_INPUT_BIT_I);
        end
    end

    // The watcher frames periods on forwarded clock rises. Before lock only the newest note
    // is kept, because words captured during the lock wait are never sent.
    always @(negedge CLK_SYS_I) begin
        if (LINK_LOCKED_O !== 1'b1) begin
            while (exp_q.size() > 1) begin
                void'(exp_q.pop_front());
            end
            have_exp = 1'b0;
            n_smp = 0;
        end else begin
            if (FORWARDED_CLOCK_O === 1'b1 && fwd_prev === 1'b0) begin
                if (have_exp) begin
                    check_period();
                end
                have_exp = (exp_q.size() > 0);
                if (have_exp) begin
                    cur_exp = exp_q.pop_front();
                end
                n_smp = 0;
            end
            if (n_smp < 16) begin
                lane_s[n_smp] = SERIAL_LANE_O;
                fwd_s[n_smp] = FORWARDED_CLOCK_O;
            end
            n_smp++;
        end
        fwd_prev = FORWARDED_CLOCK_O;
    end

    // A hang ends the run as a failure.
    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles >= CEILING) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ********************************************************
    // Scenarios.
    // ********************************************************
    // The select may only move while powered down, so it is set before release.
    task automatic run_phase(input logic sel);
        int w;
        @(posedge CLK_SYS_I);
        CAPTURE_EDGE_SELECT_I <= sel;
        repeat (4) @(posedge CLK_SYS_I);
        POWER_DOWN_N_I <= 1'b1;
        repeat (`LPS_LOCK_CYC) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        chk("locked_early", 32'(LINK_LOCKED_O), 32'h0);
        chk("oe_n_lock", 32'({SERIAL_LANE_OE_N_O, FORWARDED_CLOCK_OE_N_O}), 32'h0);
        chk("lanes_lock", 32'({SERIAL_LANE_O, FORWARDED_CLOCK_O}), 32'h0);
        w = 0;
        while (LINK_LOCKED_O !== 1'b1 && w < 100) begin
            @(negedge CLK_SYS_I);
            w++;
        end
        chk("locked", 32'(LINK_LOCKED_O), 32'h1);
        repeat (320) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        chk("oe_n_run", 32'({SERIAL_LANE_OE_N_O, FORWARDED_CLOCK_OE_N_O}), 32'h0);
    endtask

    // Power-down in mid-stream: drivers off and every output cleared after the sync delay.
    task automatic power_off();
        @(posedge CLK_SYS_I);
        POWER_DOWN_N_I <= 1'b0;
        repeat (3) @(posedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        chk("oe_n_off", 32'({SERIAL_LANE_OE_N_O, FORWARDED_CLOCK_OE_N_O}), 32'h1F);
        chk("outputs_cleared", 32'({SERIAL_LANE_O, FORWARDED_CLOCK_O, LINK_LOCKED_O}), 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge CLK_SYS_I);
        RESETN_I <= 1'b1;
        run_phase(1'b1);
        power_off();
        run_phase(1'b0);
        power_off();
        chk("periods_seen", 32'(n_per > 60), 32'h1);
        report_and_stop();
    end
endmodule
